// ===== design/wdt_pkg.sv
// shared constants and types for the windowed backup watchdog
package wdt_pkg;

  localparam int CNT_W      = 12;
  localparam int PRESCALE_W = 7;

  // register byte addresses
  localparam logic [31:0] ADDR_CONTROL = 32'h400E_1900;
  localparam logic [31:0] ADDR_MODE    = 32'h400E_1904;
  localparam logic [31:0] ADDR_STATUS  = 32'h400E_1908;

  // control register fields
  localparam int KEY_MSB     = 31;
  localparam int KEY_LSB     = 24;
  localparam int RESTART_BIT = 0;

  // status register fields
  localparam int STAT_UNF_BIT = 0;
  localparam int STAT_ERR_BIT = 1;

  localparam logic [CNT_W-1:0]      CNT_MAX      = 12'hFFF;
  localparam logic [CNT_W-1:0]      CNT_ZERO     = 12'h000;
  localparam logic [PRESCALE_W-1:0] PRESCALE_END = 7'h7F;
  localparam logic [1:0]            HTRANS_NONSEQ = 2'h2;

  // mode register layout, msb first
  typedef struct packed {
    logic [1:0]       spare;
    logic             idle_halt;
    logic             debug_halt;
    logic [CNT_W-1:0] window_limit;
    logic             disable_bit;
    logic             processor_only_reset;
    logic             reset_on_fault_enable;
    logic             fault_irq_enable;
    logic [CNT_W-1:0] reload_value;
  } mode_type;

  localparam mode_type MODE_RESET = '{
    spare:                 2'h0,
    idle_halt:             1'b0,
    debug_halt:            1'b0,
    window_limit:          CNT_MAX,
    disable_bit:           1'b1,
    processor_only_reset:  1'b0,
    reset_on_fault_enable: 1'b1,
    fault_irq_enable:      1'b0,
    reload_value:          CNT_MAX
  };

  typedef struct packed {
    logic window_error_flag;
    logic underflow_flag;
  } flags_type;

endpackage

// ===== design/windowed_backup_watchdog.sv
// windowed backup watchdog with ahb-lite register slave
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ns
module windowed_backup_watchdog
  import wdt_pkg::*;
#(
  parameter logic [7:0] RESTART_KEY = 8'hC4  // arbitrary value
) (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hwdata_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // clock sources, asynchronous
  input  wire logic        slow_rc_clk_i,
  input  wire logic        main_rc_div_clk_i,
  // system state
  input  wire logic        main_rc_enable_i,
  input  wire logic        primary_on_slow_rc_i,
  input  wire logic        debug_state_i,
  input  wire logic        idle_state_i,
  // to reset controller and interrupt controller
  output logic             watchdog_fault_line_o,
  output logic             all_reset_req_o,
  output logic             proc_reset_req_o,
  output logic             irq_o
);

  mode_type              mode;
  logic                  mode_locked;
  flags_type             flags;
  logic [CNT_W-1:0]      counter;
  logic [PRESCALE_W-1:0] prescale;
  logic                  fault_line;

  // ---------------- clock source synchronisers
  logic [1:0] slow_sync;
  logic [1:0] main_sync;
  logic       slow_q;
  logic       main_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slow_sync <= 2'h0;
      main_sync <= 2'h0;
      slow_q    <= 1'b0;
      main_q    <= 1'b0;
    end else begin
      slow_sync <= {slow_sync[0], slow_rc_clk_i};
      main_sync <= {main_sync[0], main_rc_div_clk_i};
      slow_q    <= slow_sync[1];
      main_q    <= main_sync[1];
    end
  end

  logic use_main;
  logic slow_tick;
  assign use_main  = main_rc_enable_i | primary_on_slow_rc_i;
  assign slow_tick = use_main ? (main_sync[1] & ~main_q)
                              : (slow_sync[1] & ~slow_q);

  // ---------------- ahb-lite address phase capture
  logic        ph_valid;
  logic        ph_write;
  logic [31:0] ph_addr;
  logic        addr_take;

  assign addr_take = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 32'h0000_0000;
    end else if (hready_i) begin
      ph_valid <= addr_take;
      ph_write <= hwrite_i;
      ph_addr  <= haddr_i;
    end
  end

  logic wr_ctrl;
  logic wr_mode;
  logic rd_status;
  logic restart_req;
  logic mode_load;

  assign wr_ctrl   = ph_valid & ph_write & (ph_addr == ADDR_CONTROL);
  assign wr_mode   = ph_valid & ph_write & (ph_addr == ADDR_MODE);
  assign rd_status = addr_take & ~hwrite_i & (haddr_i == ADDR_STATUS);

  // restart needs the key and a one in the restart bit
  assign restart_req = wr_ctrl
                     & (hwdata_i[KEY_MSB:KEY_LSB] == RESTART_KEY)
                     & hwdata_i[RESTART_BIT];
  assign mode_load   = wr_mode & ~mode_locked;

  // zero wait state, always okay
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b0;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // read data is prepared at the address phase edge
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (addr_take & ~hwrite_i) begin
      hrdata_o <= 32'h0000_0000;
      if (haddr_i == ADDR_MODE) begin
        hrdata_o <= mode;
      end else if (haddr_i == ADDR_STATUS) begin
        hrdata_o[STAT_UNF_BIT] <= flags.underflow_flag;
        hrdata_o[STAT_ERR_BIT] <= flags.window_error_flag;
      end
    end
  end

  // ---------------- mode register, write once
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode        <= MODE_RESET;
      mode_locked <= 1'b0;
    end else if (mode_load) begin
      mode        <= mode_type'(hwdata_i);
      mode.spare  <= 2'h0;
      mode_locked <= 1'b1;
    end
  end

  // ---------------- window check and counting
  logic window_on;
  logic window_err;
  logic restart_ok;
  logic running;
  logic step;
  logic underflow;

  assign window_on  = mode.window_limit < mode.reload_value;
  assign window_err = restart_req & window_on
                    & (counter > mode.window_limit);
  assign restart_ok = restart_req & ~window_err;
  assign running    = ~mode.disable_bit
                    & ~(debug_state_i & mode.debug_halt)
                    & ~(idle_state_i & mode.idle_halt);
  assign step       = running & slow_tick & (prescale == PRESCALE_END);
  assign underflow  = step & (counter == CNT_ZERO);

  // prescaler restarts with every reload
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale <= '0;
    end else if (restart_ok | mode_load) begin
      prescale <= '0;
    end else if (running & slow_tick) begin
      prescale <= prescale + 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter <= CNT_MAX;
    end else if (mode_load) begin
      counter <= hwdata_i[CNT_W-1:0];
    end else if (restart_ok | underflow) begin
      counter <= mode.reload_value;
    end else if (step) begin
      counter <= counter - 1'b1;
    end
  end

  // ---------------- sticky flags, set wins over read clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags <= '0;
    end else begin
      flags.underflow_flag    <= underflow
                               | (flags.underflow_flag & ~rd_status);
      flags.window_error_flag <= window_err
                               | (flags.window_error_flag & ~rd_status);
    end
  end

  logic fault_set;
  assign fault_set = (underflow & mode.reset_on_fault_enable)
                   | window_err;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_line <= 1'b0;
    end else begin
      fault_line <= fault_set | (fault_line & ~rd_status);
    end
  end

  // ---------------- registered outputs
  logic next_irq;
  logic next_req;
  assign next_irq = mode.fault_irq_enable
                  & (flags.underflow_flag | flags.window_error_flag);
  assign next_req = fault_line & mode.reset_on_fault_enable;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o                 <= 1'b0;
      watchdog_fault_line_o <= 1'b0;
      all_reset_req_o       <= 1'b0;
      proc_reset_req_o      <= 1'b0;
    end else begin
      irq_o                 <= next_irq & ~rd_status;
      watchdog_fault_line_o <= fault_line & ~rd_status;
      all_reset_req_o       <= next_req & ~rd_status
                             & ~mode.processor_only_reset;
      proc_reset_req_o      <= next_req & ~rd_status
                             & mode.processor_only_reset;
    end
  end

  // ---------------- assertions
  AST_RELOAD_AFTER_RESTART: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    restart_ok & ~mode_load |=> counter == $past(mode.reload_value) && prescale == '0)
    else $error("restart did not reload counter and prescaler");

  AST_KEY_CHECK: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    wr_ctrl & (hwdata_i[KEY_MSB:KEY_LSB] != RESTART_KEY) & ~mode_load & ~(running & slow_tick)
    |=> $stable(counter) && $stable(prescale))
    else $error("restart taken with wrong key");

  AST_MODE_ONCE: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    mode_locked |=> $stable(mode))
    else $error("mode changed after first write");

  AST_UNDERFLOW_FLAG: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    underflow |=> flags.underflow_flag && (fault_line || !$past(mode.reset_on_fault_enable)))
    else $error("underflow not recorded");

  AST_WINDOW_ERROR: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    restart_req & window_on & (counter > mode.window_limit)
    |=> flags.window_error_flag && fault_line ##1 (watchdog_fault_line_o || $past(rd_status)))
    else $error("window error missed");

  AST_WINDOW_OFF: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    restart_req & (mode.window_limit >= mode.reload_value) & ~mode_load
    |=> counter == $past(mode.reload_value))
    else $error("restart refused with window off");

  AST_IRQ: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    next_irq & ~rd_status |=> irq_o)
    else $error("interrupt not raised");

  AST_READ_CLEARS: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_status & ~fault_set & ~underflow & ~window_err
    |=> !fault_line && flags == '0 && !irq_o)
    else $error("status read did not clear");

  AST_DISABLED_HOLDS: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    mode.disable_bit & ~restart_ok & ~mode_load |=> $stable(counter))
    else $error("counter moved while disabled");

  AST_HALT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    debug_state_i & mode.debug_halt |-> !step)
    else $error("counter stepped in debug halt");

  AST_RESET_SELECT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    !(all_reset_req_o && proc_reset_req_o))
    else $error("both reset requests active");

  AST_FAULT_OUT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    fault_line & ~rd_status |=> watchdog_fault_line_o)
    else $error("fault line not passed to output");

  AST_UNDERFLOW_RELOAD: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    underflow & ~mode_load |=> counter == $past(mode.reload_value))
    else $error("underflow did not reload counter");

  AST_STEP_DECREMENT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    step & ~restart_ok & ~mode_load & (counter != CNT_ZERO)
    |=> counter == $past(counter) - 1'b1)
    else $error("counter did not step down");

  AST_MODE_LOAD: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    mode_load
    |=> mode_locked && counter == $past(hwdata_i[CNT_W-1:0]) && prescale == '0)
    else $error("mode write did not reload and restart");

  AST_REQ_SOURCE: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    all_reset_req_o || proc_reset_req_o
    |-> $past(fault_line) && $past(mode.reset_on_fault_enable))
    else $error("reset request without enabled fault");

  AST_REQ_SELECT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    all_reset_req_o || proc_reset_req_o |-> proc_reset_req_o == $past(mode.processor_only_reset))
    else $error("wrong reset request selected");

  AST_STATUS_DATA: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    rd_status |=> hrdata_o[STAT_UNF_BIT] == $past(flags.underflow_flag)
              && hrdata_o[STAT_ERR_BIT] == $past(flags.window_error_flag))
    else $error("status read data wrong");

  AST_STICKY_UNF: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    flags.underflow_flag & ~rd_status |=> flags.underflow_flag)
    else $error("underflow flag lost without read");

  AST_STICKY_ERR: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    flags.window_error_flag & ~rd_status |=> flags.window_error_flag)
    else $error("window error flag lost without read");

  AST_IDLE_HALT: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    idle_state_i & mode.idle_halt |-> !step)
    else $error("counter stepped in idle halt");

  AST_IRQ_ENABLE: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    irq_o |-> $past(mode.fault_irq_enable))
    else $error("interrupt raised while disabled");

  AST_CTRL_READ_ZERO: assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    addr_take & ~hwrite_i & (haddr_i == ADDR_CONTROL) |=> hrdata_o == '0)
    else $error("control register readable");

endmodule

// ===== sim/clock_source_model.sv
// slow clock sources seen by the watchdog, each one stands low while stopped
`timescale 1ns/1ns
module clock_source_model (
  // run controls
  input  wire logic run_slow_i,
  input  wire logic run_main_i,
  // clocks
  output logic      slow_rc_clk_o,
  output logic      main_rc_div_clk_o
);
  initial begin
    slow_rc_clk_o = 1'b0;
    main_rc_div_clk_o = 1'b0;
  end
  // 80 ns slow rc period
  always begin
    #40;
    slow_rc_clk_o = run_slow_i ? ~slow_rc_clk_o : 1'b0;
  end
  // 60 ns divided main rc period, phase unrelated to the bus clock
  always begin
    #33;
    main_rc_div_clk_o = run_main_i ? ~main_rc_div_clk_o : 1'b0;
    #27;
    main_rc_div_clk_o = run_main_i ? ~main_rc_div_clk_o : 1'b0;
  end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the windowed backup watchdog
`timescale 1ns/1ns
module tb_top;
  import wdt_pkg::*;
  localparam logic [7:0]  KEY     = 8'h5A;  // arbitrary value
  localparam logic [31:0] RESTART = {KEY, 23'h0, 1'b1};
  logic        mclk, rst_n, hsel, hwrite, hready, hresp, run_slow, run_main;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        slow_clk, main_clk, main_en, dbg, fault, all_req, proc_req, irq, prim, idle;
  mode_type    m1, m2;
  int          miscompares = 0;
  int          comparisons = 0;

  clock_source_model partner (.run_slow_i(run_slow), .run_main_i(run_main),
    .slow_rc_clk_o(slow_clk), .main_rc_div_clk_o(main_clk));

  windowed_backup_watchdog #(.RESTART_KEY(KEY)) dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .slow_rc_clk_i(slow_clk), .main_rc_div_clk_i(main_clk),
    .main_rc_enable_i(main_en), .primary_on_slow_rc_i(prim),
    .debug_state_i(dbg), .idle_state_i(idle),
    .watchdog_fault_line_o(fault), .all_reset_req_o(all_req),
    .proc_reset_req_o(proc_req), .irq_o(irq));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer, waiting on hready in both phases
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_fault(input int lim);
    int n = 0;
    while (fault !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask

  task automatic conclude();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #150000;
    miscompares++;
    conclude();
  end

  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; run_slow = 1'b1; run_main = 1'b0;
    main_en = 1'b0; dbg = 1'b0; prim = 1'b0; idle = 1'b0;
    reset_dut();
    // the primary watchdog is taken as running throughout the run
    xfer(1'b0, ADDR_MODE, 32'h0); chk(rd, MODE_RESET);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0);
    xfer(1'b0, ADDR_CONTROL, 32'h0); chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    xfer(1'b0, ADDR_STATUS + 32'h4, 32'h0); chk(rd, 32'h0);
    xfer(1'b1, ADDR_CONTROL, {8'h5B, 24'h1});
    xfer(1'b1, ADDR_CONTROL, {KEY, 24'h0});
    xfer(1'b1, ADDR_CONTROL, RESTART);
    repeat (6) @(posedge mclk);
    chk(32'(fault), 32'h0);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0);
    m1 = MODE_RESET;
    m1.reload_value = 12'h002;
    m1.window_limit = 12'h001;
    m1.disable_bit = 1'b0;
    m1.fault_irq_enable = 1'b1;
    m2 = m1;
    m2.reload_value = 12'h001;
    m2.window_limit = 12'h000;
    m2.debug_halt = 1'b1;
    m2.processor_only_reset = 1'b1;
    m2.fault_irq_enable = 1'b0;
    m2.idle_halt = 1'b1;
    // mode is programmed after the keyed restart above, a six-cycle wait and a status read
    xfer(1'b1, ADDR_MODE, m1);
    xfer(1'b1, ADDR_MODE, m2);
    xfer(1'b0, ADDR_MODE, 32'h0); chk(rd, m1);
    // counter sits above the window, so a keyed restart here would fault
    xfer(1'b1, ADDR_CONTROL, {8'h5B, 24'h1});
    repeat (3) @(posedge mclk);
    chk(32'(fault), 32'h0);
    xfer(1'b1, ADDR_CONTROL, RESTART);
    wait_fault(20); chk(32'(fault), 32'h1);
    @(posedge mclk);
    chk(32'({all_req, proc_req, irq}), 32'h5);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h2);
    chk(32'({fault, irq}), 32'h0);
    // only the divided main clock runs now
    run_slow <= 1'b0;
    run_main <= 1'b1;
    main_en <= 1'b1;
    wait_fault(4000); chk(32'(fault), 32'h1);
    @(posedge mclk);
    chk(32'({all_req, irq}), 32'h3);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h1);
    // primary watchdog on the slow rc keeps the main clock selected
    main_en <= 1'b0;
    prim <= 1'b1;
    wait_fault(4000); chk(32'(fault), 32'h1);
    reset_dut();
    chk(32'({fault, all_req, irq}), 32'h0);
    xfer(1'b0, ADDR_STATUS, 32'h0); chk(rd, 32'h0);
    dbg <= 1'b1;
    xfer(1'b1, ADDR_MODE, m2);
    repeat (1800) @(posedge mclk);
    chk(32'(fault), 32'h0);
    dbg <= 1'b0;
    idle <= 1'b1;
    repeat (1800) @(posedge mclk);
    chk(32'(fault), 32'h0);
    xfer(1'b1, ADDR_CONTROL, RESTART);
    wait_fault(20); chk(32'(fault), 32'h1);
    repeat (2) @(posedge mclk);
    chk(32'({all_req, proc_req, irq}), 32'h2);
    conclude();
  end
endmodule
